// >>> core/pcrc_fifo.sv
// Input word FIFO with a run-time depth limit
`timescale 1ns/1ps
module pcrc_fifo #(
    parameter int DEPTH = pcrc_pkg::DEPTH_SHORT
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    pcrc_fifo_if.fifo_side f // Push, pop and status
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH != (1 << PW) || DEPTH < pcrc_pkg::DEPTH_LONG || DEPTH > pcrc_pkg::DEPTH_SHORT) begin : g_chk
        $error("pcrc_fifo: DEPTH must be a power of two from 8 to 16");
    end

    logic [pcrc_pkg::DATA_W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [pcrc_pkg::COUNT_W-1:0] count_q;
    logic do_push;
    logic do_pop;

    assign f.full = count_q >= f.limit;
    assign f.empty = count_q == '0;
    assign f.count = count_q;
    assign f.pop_data = mem_q[rd_q];
    assign do_push = f.push && !f.full;
    assign do_pop = f.pop && !f.empty;

    always_ff @(posedge aclk) begin
        if (do_push) begin
            mem_q[wr_q] <= f.push_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= '0;
        end else if (do_push && !do_pop) begin
            count_q <= count_q + 1'b1;
        end else if (do_pop && !do_push) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule

// >>> core/pcrc_fifo_if.sv
// Connection between the control logic and the input word FIFO
`timescale 1ns/1ps
interface pcrc_fifo_if;
    logic push;
    logic [pcrc_pkg::DATA_W-1:0] push_data;
    logic pop;
    logic [pcrc_pkg::DATA_W-1:0] pop_data;
    logic [pcrc_pkg::COUNT_W-1:0] limit;
    logic [pcrc_pkg::COUNT_W-1:0] count;
    logic full;
    logic empty;

    modport fifo_side (input push, push_data, pop, limit, output pop_data, count, full, empty);
    modport user_side (output push, push_data, pop, limit, input pop_data, count, full, empty);
endinterface

// >>> core/pcrc_pkg.sv
// Shared constants for the programmable CRC control block
package pcrc_pkg;
    localparam int DATA_W = 16;
    localparam int COUNT_W = 5;
    localparam int ADDR_W = 5;
    localparam int DEPTH_SHORT = 16;
    localparam int DEPTH_LONG = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_POLY = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_INPUT = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h14;

    // Control register field positions
    localparam int IDLE_HALT_BIT = 13;
    localparam int COUNT_MSB = 12;
    localparam int COUNT_LSB = 8;
    localparam int FULL_BIT = 7;
    localparam int EMPTY_BIT = 6;
    localparam int GO_BIT = 4;
    localparam int POLY_LENGTH_MINUS_ONE_MSB = 3;
    localparam int POLY_LENGTH_MINUS_ONE_W = 4;

    // Length-minus-one values above this use the shallow FIFO and 16-bit words
    localparam logic [POLY_LENGTH_MINUS_ONE_W-1:0] POLY_LENGTH_MINUS_ONE_SPLIT = 4'h7;
    localparam logic [COUNT_W-1:0] LIMIT_SHORT = 5'h10;
    localparam logic [COUNT_W-1:0] LIMIT_LONG = 5'h08;
    localparam logic [COUNT_W-1:0] BITS_WIDE = 5'h10;
    localparam logic [COUNT_W-1:0] BITS_NARROW = 5'h08;

    // Interrupt status bits
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_OVF_BIT = 1;
    localparam int EVT_W = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        ST_WAIT = 1'b0,
        ST_SHIFT = 1'b1
    } pcrc_state_type;
endpackage

// >>> core/pcrc_top.sv
// Programmable CRC control block with AXI4-Lite register access
//
// Summary of operation
// - Six registers: control, taps, result, input, interrupt status, interrupt mask
// - Idle-halt bit 13 stops unit in idle
// - Bits 12-8 report FIFO word count
// - Depth 8 when length above 8, else 16
// - Bit 7 reads one while FIFO full
// - Bit 6 reads one while FIFO empty
// - Go bit 4 runs the serial shifter
// - Bits 3-0 hold polynomial length minus one
// - Status fields ignore software writes
// - Bits 15, 14 and 5 read zero
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module pcrc_top (
    input wire logic aclk, // 200 MHz clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic device_idle, // High while device is in idle mode
    input wire logic [pcrc_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection, unused
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [pcrc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection, unused
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic irq // Level interrupt
);
    localparam int DW = pcrc_pkg::DATA_W;
    localparam int CW = pcrc_pkg::COUNT_W;

    // Register address match, shared by read and write decode
    function automatic logic addr_is(
        input logic [pcrc_pkg::ADDR_W-1:0] addr,
        input logic [pcrc_pkg::ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction

    function automatic logic addr_mapped(input logic [pcrc_pkg::ADDR_W-1:0] addr);
        return addr_is(addr, pcrc_pkg::OFS_CTRL) || addr_is(addr, pcrc_pkg::OFS_POLY)
            || addr_is(addr, pcrc_pkg::OFS_RESULT) || addr_is(addr, pcrc_pkg::OFS_INPUT)
            || addr_is(addr, pcrc_pkg::OFS_IRQ_STAT) || addr_is(addr, pcrc_pkg::OFS_IRQ_MASK);
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [DW-1:0] merge16(
        input logic [DW-1:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [DW-1:0] res;
        res = old_v;
        if (strb[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // Mask of the active polynomial bits, as many bits as the length
    function automatic logic [DW-1:0] len_mask(input logic [pcrc_pkg::POLY_LENGTH_MINUS_ONE_W-1:0] poly_length_minus_one);
        logic [DW:0] ones;
        ones = (17'h00001 << ({1'b0, poly_length_minus_one} + 5'h01)) - 17'h00001;
        return ones[DW-1:0];
    endfunction

    // Bus write channel state
    logic aw_have_q;
    logic w_have_q;
    logic [pcrc_pkg::ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;

    // Bus read channel state
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_fire;

    // Software registers
    logic idle_halt_q;
    logic shifter_go_q;
    logic [pcrc_pkg::POLY_LENGTH_MINUS_ONE_W-1:0] poly_length_minus_one_q;
    logic [DW-1:0] poly_tap_q;
    logic [DW-1:0] crc_q;
    logic [pcrc_pkg::EVT_W-1:0] irq_stat_q;
    logic [pcrc_pkg::EVT_W-1:0] irq_mask_q;

    // Shifter state
    pcrc_pkg::pcrc_state_type state_q;
    logic [DW-1:0] shift_q;
    logic [CW-1:0] bits_left_q;
    logic running;
    logic long_poly;
    logic take_word;
    logic shift_bit;
    logic word_done;
    logic fb_bit;
    logic [DW-1:0] crc_next;
    logic [pcrc_pkg::EVT_W-1:0] evt;
    logic [DW-1:0] ctrl_view;

    pcrc_fifo_if fq ();

    pcrc_fifo #(
        .DEPTH(pcrc_pkg::DEPTH_SHORT)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .f(fq.fifo_side)
    );

    // Write address and data are taken in either order
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign rd_fire = s_axi_arvalid && !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= pcrc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= addr_mapped(awaddr_q) ? pcrc_pkg::RESP_OKAY : pcrc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign ctrl_view = {2'h0, idle_halt_q, fq.count, fq.full, fq.empty, 1'b0,
        shifter_go_q, poly_length_minus_one_q};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= pcrc_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= addr_mapped(s_axi_araddr) ? pcrc_pkg::RESP_OKAY : pcrc_pkg::RESP_SLVERR;
            if (addr_is(s_axi_araddr, pcrc_pkg::OFS_CTRL)) begin
                rdata_q <= {16'h0000, ctrl_view};
            end else if (addr_is(s_axi_araddr, pcrc_pkg::OFS_POLY)) begin
                rdata_q <= {16'h0000, poly_tap_q};
            end else if (addr_is(s_axi_araddr, pcrc_pkg::OFS_RESULT)) begin
                rdata_q <= {16'h0000, crc_q};
            end else if (addr_is(s_axi_araddr, pcrc_pkg::OFS_IRQ_STAT)) begin
                rdata_q <= {30'h00000000, irq_stat_q};
            end else if (addr_is(s_axi_araddr, pcrc_pkg::OFS_IRQ_MASK)) begin
                rdata_q <= {30'h00000000, irq_mask_q};
            end else begin
                // Input word register is write only
                rdata_q <= '0;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_halt_q <= 1'b0;
            shifter_go_q <= 1'b0;
            poly_length_minus_one_q <= '0;
        end else if (wr_fire && addr_is(awaddr_q, pcrc_pkg::OFS_CTRL)) begin
            if (wstrb_q[1]) begin
                idle_halt_q <= wdata_q[pcrc_pkg::IDLE_HALT_BIT];
            end
            if (wstrb_q[0]) begin
                shifter_go_q <= wdata_q[pcrc_pkg::GO_BIT];
                poly_length_minus_one_q <= wdata_q[pcrc_pkg::POLY_LENGTH_MINUS_ONE_MSB:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            poly_tap_q <= '0;
        end else if (wr_fire && addr_is(awaddr_q, pcrc_pkg::OFS_POLY)) begin
            poly_tap_q <= merge16(poly_tap_q, wdata_q, wstrb_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= '0;
        end else if (wr_fire && addr_is(awaddr_q, pcrc_pkg::OFS_IRQ_MASK) && wstrb_q[0]) begin
            irq_mask_q <= wdata_q[pcrc_pkg::EVT_W-1:0];
        end
    end

    assign long_poly = poly_length_minus_one_q > pcrc_pkg::POLY_LENGTH_MINUS_ONE_SPLIT;
    assign fq.limit = long_poly ? pcrc_pkg::LIMIT_LONG : pcrc_pkg::LIMIT_SHORT;

    // A write to a full FIFO is dropped and flagged
    assign fq.push = wr_fire && addr_is(awaddr_q, pcrc_pkg::OFS_INPUT) && (|wstrb_q[1:0]);
    assign fq.push_data = merge16('0, wdata_q, wstrb_q);

    assign running = shifter_go_q && !(idle_halt_q && device_idle);
    assign take_word = running && (state_q == pcrc_pkg::ST_WAIT) && !fq.empty;
    assign fq.pop = take_word;
    assign shift_bit = running && (state_q == pcrc_pkg::ST_SHIFT);
    assign word_done = shift_bit && (bits_left_q == 5'h01);

    // Data enters MSB first against the top polynomial bit
    assign fb_bit = crc_q[poly_length_minus_one_q] ^ shift_q[DW-1];
    assign crc_next = ({crc_q[DW-2:0], 1'b0} ^ (fb_bit ? poly_tap_q : '0))
        & len_mask(poly_length_minus_one_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= pcrc_pkg::ST_WAIT;
        end else begin
            case (state_q)
                pcrc_pkg::ST_WAIT: begin
                    if (take_word) begin
                        state_q <= pcrc_pkg::ST_SHIFT;
                    end
                end
                pcrc_pkg::ST_SHIFT: begin
                    if (word_done) begin
                        state_q <= pcrc_pkg::ST_WAIT;
                    end
                end
                default: begin
                    state_q <= pcrc_pkg::ST_WAIT;
                end
            endcase
        end
    end

    // Narrow words sit left aligned so the MSB leads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_q <= '0;
            bits_left_q <= '0;
        end else if (take_word) begin
            shift_q <= long_poly ? fq.pop_data : {fq.pop_data[7:0], 8'h00};
            bits_left_q <= long_poly ? pcrc_pkg::BITS_WIDE : pcrc_pkg::BITS_NARROW;
        end else if (shift_bit) begin
            shift_q <= {shift_q[DW-2:0], 1'b0};
            bits_left_q <= bits_left_q - 1'b1;
        end
    end

    // Shifting wins over a seed write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_q <= '0;
        end else if (shift_bit) begin
            crc_q <= crc_next;
        end else if (wr_fire && addr_is(awaddr_q, pcrc_pkg::OFS_RESULT)) begin
            crc_q <= merge16(crc_q, wdata_q, wstrb_q);
        end
    end

    always_comb begin
        evt = '0;
        evt[pcrc_pkg::EVT_DONE_BIT] = word_done && fq.empty;
        evt[pcrc_pkg::EVT_OVF_BIT] = fq.push && fq.full;
    end

    // Read clears, a new event in the same cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
        end else if (rd_fire && addr_is(s_axi_araddr, pcrc_pkg::OFS_IRQ_STAT)) begin
            irq_stat_q <= evt;
        end else begin
            irq_stat_q <= irq_stat_q | evt;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);
endmodule

// >>> testbench/pcrc_top_props.sv
// Assertions on the register bus and control fields of the CRC block
`timescale 1ns/1ps
module pcrc_top_props (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic [pcrc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic irq // Interrupt
);
    logic [pcrc_pkg::ADDR_W-1:0] rd_addr_q;
    logic [4:0] cnt;
    logic ctrl_rd;

    // Address of the read in flight, to judge what comes back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr_q <= 5'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end
    assign cnt = s_axi_rdata[12:8];
    assign ctrl_rd = s_axi_rvalid && (rd_addr_q == pcrc_pkg::OFS_CTRL);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    busy_refuse_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not on time");
    unmapped_read_a: assert property (
        s_axi_rvalid && (rd_addr_q > pcrc_pkg::OFS_IRQ_MASK) |->
        s_axi_rresp == pcrc_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    ctrl_unused_a: assert property (
        ctrl_rd |-> s_axi_rdata[31:14] == 18'h00000 && !s_axi_rdata[5])
        else $error("unused control bits not zero");
    empty_flag_a: assert property (
        ctrl_rd |-> s_axi_rdata[6] == (cnt == 5'h00))
        else $error("empty flag disagrees with count");
    full_flag_a: assert property (
        ctrl_rd |-> s_axi_rdata[7] == (cnt >= ((s_axi_rdata[3:0] > pcrc_pkg::POLY_LENGTH_MINUS_ONE_SPLIT) ?
        pcrc_pkg::LIMIT_LONG : pcrc_pkg::LIMIT_SHORT)))
        else $error("full flag disagrees with count");
    count_max_a: assert property (
        ctrl_rd |-> cnt <= pcrc_pkg::LIMIT_SHORT)
        else $error("word count above depth");
    reset_idle_a: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs active after reset");
endmodule

bind pcrc_top pcrc_top_props props_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .irq(irq)
);

// >>> testbench/pcrc_top_tb.sv
// Self-checking bench for the CRC control block
`timescale 1ns/1ps
module pcrc_top_tb;
    logic aclk = 1'b0, aresetn = 1'b0, device_idle = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd_data;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    int miscompares = 0, checks_done = 0, cycles = 0;

    pcrc_top dut_u (
        .aclk(aclk), .aresetn(aresetn), .device_idle(device_idle),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq)
    );

    always #2.5 aclk = ~aclk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Far fewer cycles than this are needed; a hang ends here
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Go stays off, so every push up to the limit must stay counted
    task automatic fill(input logic [3:0] poly_length_minus_one, input int lim);
        wr(pcrc_pkg::OFS_CTRL, {28'h0000000, poly_length_minus_one});
        for (int i = 1; i <= lim + 1; i++) begin
            wr(pcrc_pkg::OFS_INPUT, 32'h000000A0 + i);
            rd(pcrc_pkg::OFS_CTRL);
            check("count", rd_data[12:8], (i > lim) ? lim : i);
            check("full", rd_data[7], i >= lim);
            check("empty", rd_data[6], 1'b0);
        end
    endtask

    task automatic drain(input int start);
        int prev;
        prev = start;
        for (int k = 0; k < 100 && prev != 0; k++) begin
            rd(pcrc_pkg::OFS_CTRL);
            check("count falls", rd_data[12:8] <= prev, 1'b1);
            prev = rd_data[12:8];
        end
        // Last popped word may still be shifting; let it finish
        repeat (20) @(posedge aclk);
        check("drained", rd_data[12:6], 7'h01);
    endtask

    task automatic t_fields();
        rd(pcrc_pkg::OFS_CTRL);
        check("ctrl reset", rd_data, 32'h00000040);
        check("irq reset", irq, 1'b0);
        wr(pcrc_pkg::OFS_CTRL, 32'hFFFFFFEF);
        rd(pcrc_pkg::OFS_CTRL);
        check("ctrl fields", rd_data, 32'h0000204F);
        wr(pcrc_pkg::OFS_POLY, 32'h00001234);
        check("taps wresp", wr_resp, pcrc_pkg::RESP_OKAY);
        rd(pcrc_pkg::OFS_POLY);
        check("taps", rd_data, 32'h00001234);
        rd(pcrc_pkg::OFS_INPUT);
        check("input read", rd_data, 32'h00000000);
        rd(5'h18);
        check("hole resp", rd_resp, pcrc_pkg::RESP_SLVERR);
        wr(5'h18, 32'h00000001);
        check("hole wresp", wr_resp, pcrc_pkg::RESP_SLVERR);
        wr(pcrc_pkg::OFS_CTRL, 32'h00000000);
        $display("field test done");
    endtask

    task automatic t_short();
        fill(4'h7, 16);
        check("irq masked", irq, 1'b0);
        wr(pcrc_pkg::OFS_IRQ_MASK, 32'h00000002);
        check("irq raised", irq, 1'b1);
        rd(pcrc_pkg::OFS_IRQ_STAT);
        check("overflow", rd_data, 32'h00000002);
        repeat (2) @(posedge aclk);
        check("irq cleared", irq, 1'b0);
        wr(pcrc_pkg::OFS_CTRL, 32'h00000017);
        drain(16);
        wr(pcrc_pkg::OFS_CTRL, 32'h00000000);
        $display("short fill test done");
    endtask

    task automatic t_long();
        fill(4'hF, 8);
        device_idle <= 1'b1;
        wr(pcrc_pkg::OFS_CTRL, 32'h0000201F);
        repeat (40) @(posedge aclk);
        rd(pcrc_pkg::OFS_CTRL);
        check("halted", rd_data[12:8], 5'h08);
        device_idle <= 1'b0;
        drain(8);
        wr(pcrc_pkg::OFS_CTRL, 32'h0000000F);
        device_idle <= 1'b1;
        wr(pcrc_pkg::OFS_INPUT, 32'h00001111);
        wr(pcrc_pkg::OFS_INPUT, 32'h00002222);
        wr(pcrc_pkg::OFS_CTRL, 32'h0000001F);
        drain(2);
        device_idle <= 1'b0;
        wr(pcrc_pkg::OFS_CTRL, 32'h00000000);
        $display("long fill test done");
    endtask

    task automatic t_crc();
        logic [7:0] c;
        logic [7:0] d;
        c = 8'h00;
        d = 8'hA5;
        for (int b = 7; b >= 0; b--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[b]) ? 8'h07 : 8'h00);
        end
        wr(pcrc_pkg::OFS_CTRL, 32'h00000007);
        wr(pcrc_pkg::OFS_POLY, 32'h00000007);
        wr(pcrc_pkg::OFS_RESULT, 32'h00000000);
        rd(pcrc_pkg::OFS_IRQ_STAT);
        wr(pcrc_pkg::OFS_INPUT, 32'h000000A5);
        wr(pcrc_pkg::OFS_IRQ_MASK, 32'h00000001);
        wr(pcrc_pkg::OFS_CTRL, 32'h00000017);
        for (int k = 0; k < 50 && irq !== 1'b1; k++) @(posedge aclk);
        check("done irq", irq, 1'b1);
        rd(pcrc_pkg::OFS_RESULT);
        check("crc", rd_data, {24'h000000, c});
        rd(pcrc_pkg::OFS_IRQ_STAT);
        check("done flag", rd_data, 32'h00000001);
        wr(pcrc_pkg::OFS_CTRL, 32'h00000000);
        $display("crc test done");
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_fields();
        t_short();
        t_long();
        t_crc();
        summarize();
    end
endmodule
